// File: bench/iet_event_src.sv
`timescale 1ns/100ps
module iet_event_src (
   input  wire logic       pclk,
   input  wire logic       run,
   input  wire logic [3:0] half,
   output logic            event_in
);
   logic [3:0] cnt_q;
   initial begin
      cnt_q    = 4'h0;
      event_in = 1'b0;
   end
   // ======================================================
   // event source: square wave of half-period half, held low when idle
   always @(posedge pclk) begin
      if (!run) begin
         cnt_q    <= 4'h0;
         event_in <= 1'b0;
      end else if (cnt_q == half - 4'h1) begin
         cnt_q    <= 4'h0;
         event_in <= ~event_in;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule : iet_event_src

// File: bench/tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH %0t %s", $time, m); end end
module tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, event_in, run, clr;
   logic [4:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic        p0_out, p1_out, irq0, irq1, ovf_irq, p0_q, p1_q;
   logic [3:0]  half;
   int          mismatches, checked, cyc, tg0, tg1, ovf, t0, c;
   int          q0[$], q1[$];
   iet_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .event_in(event_in), .primary_timer_out(p0_out),
      .secondary_timer_out(p1_out), .period_match_irq(irq0), .secondary_match_irq(irq1),
      .overflow_irq(ovf_irq));
   iet_event_src u_src (.pclk(pclk), .run(run), .half(half), .event_in(event_in));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // ======================================================
   // reference model: irq times and pin toggles
   always @(posedge pclk) begin
      cyc  <= cyc + 1;
      p0_q <= p0_out;
      p1_q <= p1_out;
      if (ovf_irq !== 1'b0) ovf <= ovf + 1;
      if (clr) begin
         q0.delete();
         q1.delete();
         tg0 <= 0;
         tg1 <= 0;
      end else begin
         if (irq0 === 1'b1) q0.push_back(cyc);
         if (irq1 === 1'b1) q1.push_back(cyc);
         if (p0_out !== p0_q) tg0 <= tg0 + 1;
         if (p1_out !== p1_q) tg1 <= tg1 + 1;
      end
   end
   function automatic bit gaps_ok(input int q[$], input int g);
      bit ok;
      ok = (q.size() >= 2);
      for (int i = 1; i < q.size(); i++) if (q[i] - q[i-1] != g) ok = 1'b0;
      return ok;
   endfunction : gaps_ok
   task final_report;
      $display("mismatches=%0d checked=%0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   task timeout;
      mismatches++;
      $display("MISMATCH %0t wait limit reached", $time);
      final_report();
   endtask : timeout
   // ======================================================
   // apb master
   task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) timeout();
      r       = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic wait_irq(input int n);
      int i;
      for (i = 0; i < n; i++) begin
         @(posedge pclk);
         if (irq0 === 1'b1) break;
      end
      if (i == n) timeout();
   endtask : wait_irq
   task automatic measure(input int n);
      // long enough to swallow the start toggle at the first event edge
      clr <= 1'b1;
      repeat (40) @(posedge pclk);
      clr <= 1'b0;
      repeat (n) @(posedge pclk);
      // let the model's updates of this edge settle before any compare
      @(negedge pclk);
   endtask : measure
   // ======================================================
   // main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, presetn, run, clr} = '0;
      half = 4'h4;
      {mismatches, checked, cyc, tg0, tg1, ovf} = '0;
      void'($urandom(32'h8e890c78));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, iet_pkg::IET_ADDR_CTL0, 32'h0);
      `CHK(r[7:0], iet_pkg::IET_CTL_RST, "control reset value")
      apb(1'b0, iet_pkg::IET_ADDR_CNT, 32'h0);
      `CHK(r[15:0], 16'hffff, "idle count")
      apb(1'b0, 5'h1d, 32'h0);
      `CHK({err, r}, {1'b1, 32'h0}, "unmapped read")
      c = 2 + $urandom % 8;
      wr(iet_pkg::IET_ADDR_IOC0, 32'h05);
      wr(iet_pkg::IET_ADDR_CTL1, 32'h00);
      wr(iet_pkg::IET_ADDR_CCR0, c);
      wr(iet_pkg::IET_ADDR_CCR1, c - 1);
      wr(iet_pkg::IET_ADDR_CTL0, 32'h80);
      measure(12 * (c + 1));
      `CHK(gaps_ok(q0, c + 1), 1'b1, "period interval")
      `CHK(tg0, q0.size(), "primary toggles")
      `CHK(gaps_ok(q1, c + 1), 1'b1, "secondary interval")
      `CHK(tg1, q1.size(), "secondary toggles")
      wr(iet_pkg::IET_ADDR_CTL0, 32'h00);
      wr(iet_pkg::IET_ADDR_CCR0, 32'h0);
      wr(iet_pkg::IET_ADDR_CCR1, 32'h3);
      wr(iet_pkg::IET_ADDR_CTL0, 32'h80);
      measure(20);
      `CHK(gaps_ok(q0, 1), 1'b1, "zero period interval")
      `CHK(tg0, q0.size(), "zero period toggles")
      `CHK(q1.size() + tg1, 0, "secondary above period")
      apb(1'b0, iet_pkg::IET_ADDR_CNT, 32'h0);
      `CHK(r[15:0], 16'h0000, "count at zero period")
      wr(iet_pkg::IET_ADDR_CTL0, 32'h00);
      measure(20);
      `CHK(q0.size() + q1.size() + tg0 + tg1, 0, "halted activity")
      wr(iet_pkg::IET_ADDR_IOC0, 32'h00);
      wr(iet_pkg::IET_ADDR_CCR0, 32'h3);
      wr(iet_pkg::IET_ADDR_CCR1, 32'h1);
      wr(iet_pkg::IET_ADDR_CTL0, 32'h80);
      measure(30);
      `CHK({p0_out, p1_out, tg0 == 0}, 3'b001, "disabled pins")
      `CHK(q0.size() > 0, 1'b1, "irq with pins disabled")
      wr(iet_pkg::IET_ADDR_CTL0, 32'h00);
      wr(iet_pkg::IET_ADDR_CCR0, 32'd200);
      wr(iet_pkg::IET_ADDR_IOC0, 32'h05);
      wr(iet_pkg::IET_ADDR_CTL0, 32'h80);
      wait_irq(400);
      t0 = cyc;
      repeat (60) @(posedge pclk);
      wr(iet_pkg::IET_ADDR_CCR0, 32'h5);
      wait_irq(70000);
      `CHK(cyc - t0, 65536 + 5 + 1, "wrap interval")
      for (int k = 0; k < 2; k++) begin
         c = 2 + $urandom % 4;
         half <= 4'(4 + $urandom % 4);
         wr(iet_pkg::IET_ADDR_CTL0, 32'h00);
         wr(iet_pkg::IET_ADDR_CTL1, k ? 32'h01 : 32'h20);
         wr(iet_pkg::IET_ADDR_IOC2, 32'h04);
         wr(iet_pkg::IET_ADDR_CCR0, c);
         wr(iet_pkg::IET_ADDR_CCR1, 32'h1);
         run <= 1'b1;
         wr(iet_pkg::IET_ADDR_CTL0, 32'h80);
         measure(8 * half * (c + 1));
         `CHK(gaps_ok(q0, 2 * half * (c + 1)), 1'b1, "edge interval")
         `CHK(gaps_ok(q1, 2 * half * (c + 1)), 1'b1, "edge secondary")
         `CHK(tg0, k ? 0 : q0.size(), "edge mode toggles")
         if (k) `CHK(p0_out, 1'b0, "event mode pin")
         run <= 1'b0;
      end
      apb(1'b0, iet_pkg::IET_ADDR_OPT0, 32'h0);
      `CHK(r, 32'h0, "overflow flag")
      `CHK(ovf, 0, "overflow irq")
      final_report();
   end
endmodule : tb_top

// File: hdl/iet_pkg.sv
// Notes on behaviour
// - zero period: counter stays zero, match every tick
// - full period wraps with match, never overflow
// - period write goes to buffer at once
// - lowered period below count waits for wrap
// - secondary below period: one match per cycle
// - secondary above period never matches
// - event mode start clears counter, loads buffer
// - event mode match clears counter, raises irq
// - event mode never drives timer outputs
// - event mode still raises secondary match irq
// - event mode full period wraps, no overflow
// - mode code 000 interval, 001 event count
// - interval mode may count event edges
// - counter read register returns live count
// - cleared output enable disables its pin
// - interval match clears, toggles, raises irq
package iet_pkg;
   // ======================================================
   // register map (byte addresses)
   localparam logic [4:0] IET_ADDR_CTL0 = 5'h00;
   localparam logic [4:0] IET_ADDR_CTL1 = 5'h04;
   localparam logic [4:0] IET_ADDR_IOC0 = 5'h08;
   localparam logic [4:0] IET_ADDR_IOC2 = 5'h0c;
   localparam logic [4:0] IET_ADDR_CNT  = 5'h10;
   localparam logic [4:0] IET_ADDR_CCR0 = 5'h14;
   localparam logic [4:0] IET_ADDR_CCR1 = 5'h18;
   localparam logic [4:0] IET_ADDR_OPT0 = 5'h1c;
   // ======================================================
   // field positions
   localparam int IET_CE_BIT   = 7;
   localparam int IET_EEE_BIT  = 5;
   localparam int IET_OE0_BIT  = 0;
   localparam int IET_OL0_BIT  = 1;
   localparam int IET_OE1_BIT  = 2;
   localparam int IET_OL1_BIT  = 3;
   localparam int IET_EES_LO   = 2;
   // ======================================================
   // codes and reset values
   localparam logic [2:0]  IET_MODE_INTERVAL = 3'h0;
   localparam logic [2:0]  IET_MODE_EVENT    = 3'h1;
   localparam logic [1:0]  IET_EDGE_NONE     = 2'h0;
   localparam logic [1:0]  IET_EDGE_RISE     = 2'h1;
   localparam logic [1:0]  IET_EDGE_FALL     = 2'h2;
   localparam logic [7:0]  IET_CTL_RST       = 8'h00;
   localparam logic [15:0] IET_CCR_RST       = 16'h0000;
   localparam logic [15:0] IET_CNT_IDLE      = 16'hffff;
   localparam logic [15:0] IET_CNT_ZERO      = 16'h0000;
   localparam logic [7:0]  IET_PRE_RST       = 8'h00;

   typedef struct packed {
      logic [7:0]  ctl0;
      logic [7:0]  ctl1;
      logic [7:0]  ioc0;
      logic [7:0]  ioc2;
      logic [15:0] ccr0;
      logic [15:0] ccr1;
      logic [15:0] buf0;
      logic [15:0] buf1;
      logic [15:0] cnt;
      logic [7:0]  pre;
      logic        running;
      logic        tff0;
      logic        tff1;
      logic        pin0;
      logic        pin1;
      logic        irq0;
      logic        irq1;
      logic [2:0]  ev_sync;
      logic [31:0] rdata;
   } iet_state_t;
endpackage : iet_pkg

// File: hdl/iet_timer.sv
`timescale 1ns/100ps
module iet_timer (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [4:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        event_in,
   output logic             primary_timer_out,
   output logic             secondary_timer_out,
   output logic             period_match_irq,
   output logic             secondary_match_irq,
   output logic             overflow_irq
);
   // ======================================================
   // helpers
   function automatic logic addr_ok(input logic [4:0] a);
      addr_ok = (a == iet_pkg::IET_ADDR_CTL0) || (a == iet_pkg::IET_ADDR_CTL1) ||
                (a == iet_pkg::IET_ADDR_IOC0) || (a == iet_pkg::IET_ADDR_IOC2) ||
                (a == iet_pkg::IET_ADDR_CNT)  || (a == iet_pkg::IET_ADDR_CCR0) ||
                (a == iet_pkg::IET_ADDR_CCR1) || (a == iet_pkg::IET_ADDR_OPT0);
   endfunction : addr_ok

   // prescaler terminal count: divide by 2^sel
   function automatic logic pre_done(input logic [7:0] p, input logic [2:0] sel);
      logic [7:0] mask;
      mask = 8'(~(8'hff << sel));
      pre_done = ((p & mask) == mask);
   endfunction : pre_done

   iet_pkg::iet_state_t s_q;
   iet_pkg::iet_state_t s_d;

   logic       setup;
   logic       acc_wr;
   logic [2:0] mode;
   logic       ce;
   logic       ev_edge;
   logic       tick;
   logic       mode_ok;
   logic       is_event;
   logic       match0;
   logic       match1;

   // ======================================================
   // bus slave: zero wait state, read data latched in setup
   assign setup   = psel && !penable;
   assign acc_wr  = psel && penable && pwrite && addr_ok(paddr);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok(paddr);
   assign prdata  = s_q.rdata;

   assign mode     = s_q.ctl1[2:0];
   assign ce       = s_q.ctl0[iet_pkg::IET_CE_BIT];
   assign mode_ok  = (mode == iet_pkg::IET_MODE_INTERVAL) ||
                     (mode == iet_pkg::IET_MODE_EVENT);
   assign is_event = (mode == iet_pkg::IET_MODE_EVENT);

   // ======================================================
   // event edge detect on synchronised input
   always_comb begin
      case (s_q.ioc2[iet_pkg::IET_EES_LO +: 2])
         iet_pkg::IET_EDGE_NONE: ev_edge = 1'b0;
         iet_pkg::IET_EDGE_RISE: ev_edge = s_q.ev_sync[1] && !s_q.ev_sync[2];
         iet_pkg::IET_EDGE_FALL: ev_edge = !s_q.ev_sync[1] && s_q.ev_sync[2];
         default:                ev_edge = s_q.ev_sync[1] ^ s_q.ev_sync[2];
      endcase
   end

   // count clock: event edges in event mode or with event clock select
   always_comb begin
      if (is_event || s_q.ctl1[iet_pkg::IET_EEE_BIT]) begin
         tick = ev_edge;
      end else begin
         tick = pre_done(s_q.pre, s_q.ctl0[2:0]);
      end
   end

   assign match0 = (s_q.cnt == s_q.buf0);
   assign match1 = (s_q.cnt == s_q.buf1);

   // ======================================================
   // next state
   always_comb begin
      s_d      = s_q;
      s_d.irq0 = 1'b0;
      s_d.irq1 = 1'b0;
      s_d.ev_sync = {s_q.ev_sync[1:0], event_in};
      s_d.pre  = s_q.pre + 8'h01;
      if (setup) begin
         case (paddr)
            iet_pkg::IET_ADDR_CTL0: s_d.rdata = {24'h0, s_q.ctl0};
            iet_pkg::IET_ADDR_CTL1: s_d.rdata = {24'h0, s_q.ctl1};
            iet_pkg::IET_ADDR_IOC0: s_d.rdata = {24'h0, s_q.ioc0};
            iet_pkg::IET_ADDR_IOC2: s_d.rdata = {24'h0, s_q.ioc2};
            iet_pkg::IET_ADDR_CNT:  s_d.rdata = {16'h0, s_q.cnt};
            iet_pkg::IET_ADDR_CCR0: s_d.rdata = {16'h0, s_q.ccr0};
            iet_pkg::IET_ADDR_CCR1: s_d.rdata = {16'h0, s_q.ccr1};
            default:                s_d.rdata = 32'h0;
         endcase
      end
      if (acc_wr) begin
         case (paddr)
            iet_pkg::IET_ADDR_CTL0: s_d.ctl0 = pwdata[7:0] & 8'h87;
            iet_pkg::IET_ADDR_CTL1: s_d.ctl1 = pwdata[7:0] & 8'h67;
            iet_pkg::IET_ADDR_IOC0: s_d.ioc0 = pwdata[7:0] & 8'h0f;
            iet_pkg::IET_ADDR_IOC2: s_d.ioc2 = pwdata[7:0] & 8'h0f;
            iet_pkg::IET_ADDR_CCR0: begin
               s_d.ccr0 = pwdata[15:0];
               s_d.buf0 = pwdata[15:0];
            end
            iet_pkg::IET_ADDR_CCR1: begin
               s_d.ccr1 = pwdata[15:0];
               s_d.buf1 = pwdata[15:0];
            end
            default: begin
            end
         endcase
      end
      if (!ce || !mode_ok) begin
         // halted: counter parked, outputs back to idle
         s_d.cnt     = iet_pkg::IET_CNT_IDLE;
         s_d.running = 1'b0;
         s_d.tff0    = 1'b0;
         s_d.tff1    = 1'b0;
         s_d.pre     = iet_pkg::IET_PRE_RST;
         if (!acc_wr || paddr != iet_pkg::IET_ADDR_CCR0) begin
            s_d.buf0 = s_q.ccr0;
         end
         if (!acc_wr || paddr != iet_pkg::IET_ADDR_CCR1) begin
            s_d.buf1 = s_q.ccr1;
         end
      end else if (tick) begin
         if (!s_q.running) begin
            // first count clock clears from ffff
            s_d.running = 1'b1;
            s_d.cnt     = iet_pkg::IET_CNT_ZERO;
            s_d.tff0    = s_q.tff0 ^ !is_event;
         end else begin
            if (match0) begin
               s_d.cnt  = iet_pkg::IET_CNT_ZERO;
               s_d.irq0 = 1'b1;
               s_d.tff0 = s_q.tff0 ^ !is_event;
            end else begin
               s_d.cnt  = s_q.cnt + 16'h0001;
            end
            if (match1) begin
               s_d.irq1 = 1'b1;
               s_d.tff1 = s_q.tff1 ^ !is_event;
            end
         end
      end
      s_d.pin0 = !is_event && s_q.ioc0[iet_pkg::IET_OE0_BIT] &&
                 (s_d.tff0 ^ s_q.ioc0[iet_pkg::IET_OL0_BIT]);
      s_d.pin1 = !is_event && s_q.ioc0[iet_pkg::IET_OE1_BIT] &&
                 (s_d.tff1 ^ s_q.ioc0[iet_pkg::IET_OL1_BIT]);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q         <= '0;
         s_q.cnt     <= iet_pkg::IET_CNT_IDLE;
         s_q.buf0    <= iet_pkg::IET_CCR_RST;
         s_q.ctl0    <= iet_pkg::IET_CTL_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign primary_timer_out   = s_q.pin0;
   assign secondary_timer_out = s_q.pin1;
   assign period_match_irq    = s_q.irq0;
   assign secondary_match_irq = s_q.irq1;
   // no overflow in interval or event count operation
   assign overflow_irq        = 1'b0;

   // ======================================================
   // checks
   chk_halt_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      !ce |=> !period_match_irq && !secondary_match_irq && s_q.cnt == 16'hffff)
      else $error("halted timer counted or matched");
   chk_match_clear: assert property (@(posedge pclk) disable iff (!presetn)
      period_match_irq |-> s_q.cnt == 16'h0000 && $past(s_q.cnt) == $past(s_q.buf0))
      else $error("period match without clear");
   chk_zero_period: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.running && s_q.buf0 == 16'h0000 && $past(s_q.buf0) == 16'h0000
      |-> s_q.cnt == 16'h0000)
      else $error("zero period counter left zero");
   chk_full_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.running && tick && s_q.cnt == 16'hffff && s_q.buf0 == 16'hffff && ce && mode_ok
      |=> period_match_irq && !overflow_irq)
      else $error("full period wrap wrong");
   chk_late_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      ce && mode_ok && s_q.running && tick && s_q.cnt == 16'hffff && s_q.buf0 != 16'hffff
      && !acc_wr |=> s_q.cnt == 16'h0000 && !period_match_irq)
      else $error("wrap past lowered period wrong");
   chk_ccr0_now: assert property (@(posedge pclk) disable iff (!presetn)
      acc_wr && paddr == iet_pkg::IET_ADDR_CCR0 |=> s_q.buf0 == $past(pwdata[15:0]))
      else $error("period buffer not loaded at once");
   chk_sec_match: assert property (@(posedge pclk) disable iff (!presetn)
      secondary_match_irq |-> $past(s_q.cnt) == $past(s_q.buf1) && $past(ce))
      else $error("secondary match on wrong count");
   chk_event_pins: assert property (@(posedge pclk) disable iff (!presetn)
      is_event |=> !primary_timer_out && !secondary_timer_out)
      else $error("event mode drove timer outputs");
   chk_oe_off: assert property (@(posedge pclk) disable iff (!presetn)
      !s_q.ioc0[iet_pkg::IET_OE0_BIT] |=> !primary_timer_out)
      else $error("disabled primary output driven");
   chk_read_cnt: assert property (@(posedge pclk) disable iff (!presetn)
      setup && paddr == iet_pkg::IET_ADDR_CNT |=> prdata == {16'h0, $past(s_q.cnt)})
      else $error("counter read mismatch");

   cov_interval_irq: cover property (@(posedge pclk) disable iff (!presetn)
      !is_event && period_match_irq);
   cov_event_irq: cover property (@(posedge pclk) disable iff (!presetn)
      is_event && period_match_irq);
   cov_sec_irq: cover property (@(posedge pclk) disable iff (!presetn)
      secondary_match_irq && secondary_timer_out);
   cov_wrap: cover property (@(posedge pclk) disable iff (!presetn)
      s_q.running && s_q.cnt == 16'hffff ##1 s_q.cnt == 16'h0000);
endmodule : iet_timer
